//--- tsic_params.svh
// Offsets, field positions and reset values of the TDM serial interface configuration block
// Function
// RQ1: Mode register clears to zero on hard reset.
// RQ2: Clock route register clears to zero on reset.
// RQ3: Each TDM half has management connect bit and three-bit clock source.
// RQ4: Two-bit diagnostic field per TDM: normal, echo or loopback; zero is normal.
// RQ5: Two-bit receive and transmit sync delay fields; one delays sync one clock.
// RQ6: Common clocking uses receive clock and sync for both directions.
// RQ7: Per-TDM bits for double-speed clock, transmit clock edge, sync edge.
// RQ8: Per-TDM bit holds transmit line fixed until serial clocks run; STZ never acts, as it is loaded at the receive sync that sets link_seen_reg.
// RQ9: One grant-mode support bit per TDM in the mode register.
// RQ10: Per controller a bit selecting TDM (set) or non-multiplexed path (clear).
// RQ11: Per controller three-bit clock selects, ignored while TDM-connected.
// RQ12: Per controller one grant-mode support bit, cleared by default.
// RQ13: Software enables slot strobes on only one of two ports.
// RQ14: Last table entry carries last-entry flag; device wraps to first entry.
// RQ15: Division field binary 10 gives first TDM 32 receive and 32 transmit entries.
// RQ16: Software sets upper division bit whenever second TDM is used.
// RQ17: Separate enable per TDM in global mode register; no routing while disabled.
// RQ18: Registers read back last written value; writes apply at next frame boundary.
`ifndef TSIC_PARAMS_SVH
`define TSIC_PARAMS_SVH

`define TSIC_OFF_MODE      12'h000
`define TSIC_OFF_ROUTE     12'h004
`define TSIC_OFF_GLOBAL    12'h008
`define TSIC_OFF_STATUS    12'h00c
`define TSIC_PAGE_RX_TAB   4'h1
`define TSIC_PAGE_TX_TAB   4'h2

`define TSIC_MODE_RST      32'h0000_0000
`define TSIC_ROUTE_RST     32'h0000_0000
`define TSIC_GLOBAL_RST    4'h0

`define TSIC_MD_HALF       16
`define TSIC_MD_CONNECT    15
`define TSIC_MD_CS_LSB     12
`define TSIC_MD_DIAG_LSB   10
`define TSIC_MD_RFSD_LSB   8
`define TSIC_MD_DSC        7
`define TSIC_MD_CRT        6
`define TSIC_MD_STZ        5
`define TSIC_MD_CE         4
`define TSIC_MD_FE         3
`define TSIC_MD_GM         2
`define TSIC_MD_TFSD_LSB   0

`define TSIC_RT_STRIDE     8
`define TSIC_RT_GRANT      7
`define TSIC_RT_CONNECT    6
`define TSIC_RT_RXCS_LSB   3
`define TSIC_RT_TXCS_LSB   0

`define TSIC_GM_ENA        0
`define TSIC_GM_ENB        1
`define TSIC_GM_RDM_LSB    2

`define TSIC_EN_LAST       15
`define TSIC_EN_STRB_LSB   11
`define TSIC_EN_CTRL_LSB   9
`define TSIC_EN_VALID      8

`define TSIC_LIMIT_SPLIT   6'd31
`define TSIC_LIMIT_FULL    6'd63
`define TSIC_RESP_OKAY     2'b00
`define TSIC_RESP_SLVERR   2'b10

`endif

//--- tsic_pkg.sv
// Types of the TDM serial interface configuration block
package tsic_pkg;
   typedef logic [31:0] tsic_word_t;
   typedef logic [15:0] tsic_entry_t;
   typedef enum logic [1:0] {
      TSIC_DIAG_NORMAL   = 2'h0,
      TSIC_DIAG_ECHO     = 2'h1,
      TSIC_DIAG_LOOPBACK = 2'h2,
      TSIC_DIAG_LOOPCTRL = 2'h3
   } tsic_diag_t;
   typedef enum logic {TSIC_LK_IDLE, TSIC_LK_RUN} tsic_link_st_t;
endpackage

//--- tsic_config.sv
// TDM serial interface configuration registers with first-TDM routing logic
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tsic_params.svh"

module tsic_config
(
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire tsic_pkg::tsic_word_t s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  tsic_pkg::tsic_word_t s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                line_rx_clock,
   input  wire logic                line_rx_sync,
   input  wire logic                line_tx_sync,
   input  wire logic                line_rx_data,
   input  wire logic [3:0]          ctrl_tx_data,
   output var  logic                line_tx_data,
   output var  logic [3:0]          slot_strobe,
   output var  logic                rx_route_valid,
   output var  logic [1:0]          rx_route_ctrl,
   output var  logic                rx_route_data,
   output var  logic [1:0]          tx_route_ctrl,
   output var  tsic_pkg::tsic_word_t tdm_mode_active,
   output var  logic [1:0]          mgmt_ctrl_tdm_connect,
   output var  logic [5:0]          mgmt_ctrl_clock_source,
   output var  logic [3:0]          controller_tdm_connect,
   output var  logic [11:0]         rx_clock_select,
   output var  logic [11:0]         tx_clock_select,
   output var  logic [3:0]          controller_grant_support
);
   import tsic_pkg::*;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic tsic_word_t fn_merge(input tsic_word_t old_v, input tsic_word_t new_v,
                                           input logic [3:0] strb);
      tsic_word_t r;
      r = old_v;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      return r;
   endfunction

   // Remaining sync delay for the next link cycle
   function automatic logic [1:0] fn_dly_next(input logic sync, input logic [1:0] dly,
                                              input logic [1:0] cur);
      if (sync)
         return dly;
      else if (cur != 2'h0)
         return 2'(cur - 2'h1);
      else
         return 2'h0;
   endfunction

   // Next {entry index, bit} after the current bit; wraps on last flag or table end
   function automatic logic [8:0] fn_adv(input logic [5:0] idx, input logic [2:0] bitn,
                                         input logic last, input logic [5:0] limit);
      if (bitn != 3'h7)
         return {idx, 3'(bitn + 3'h1)};
      else if (last || idx == limit)
         return 9'h000;
      else
         return {6'(idx + 6'h1), 3'h0};
   endfunction

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Registers and routing tables
   // ------------------------------------------------------------
   tsic_word_t  mode_reg;
   tsic_word_t  route_reg;
   logic [3:0]  global_reg;
   tsic_entry_t rx_tab [64];
   tsic_entry_t tx_tab [64];
   logic [11:0] awaddr_reg;
   tsic_word_t  wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic        wr_go;
   logic [1:0]  pend_s;
   logic        link_seen_s;
   logic        link_en_s;

   assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_reg   <= `TSIC_MODE_RST;      // RQ1
         route_reg  <= `TSIC_ROUTE_RST;     // RQ2
         global_reg <= `TSIC_GLOBAL_RST;
      end
      else if (wr_go)
      begin
         // Mode and route stored as written, read back unchanged; global keeps bits 3:0 only
         if (awaddr_reg == `TSIC_OFF_MODE)
            mode_reg <= fn_merge(mode_reg, wdata_reg, wstrb_reg);   // RQ18
         if (awaddr_reg == `TSIC_OFF_ROUTE)
            route_reg <= fn_merge(route_reg, wdata_reg, wstrb_reg); // RQ18
         if (awaddr_reg == `TSIC_OFF_GLOBAL && wstrb_reg[0])
            global_reg <= wdata_reg[3:0];                            // RQ17
      end
   end

   always_ff @(posedge clk)
   begin
      if (wr_go && awaddr_reg[11:8] == `TSIC_PAGE_RX_TAB)
         rx_tab[awaddr_reg[7:2]] <= 16'(fn_merge({16'h0000, rx_tab[awaddr_reg[7:2]]},
                                                 wdata_reg, wstrb_reg));
      if (wr_go && awaddr_reg[11:8] == `TSIC_PAGE_TX_TAB)
         tx_tab[awaddr_reg[7:2]] <= 16'(fn_merge({16'h0000, tx_tab[awaddr_reg[7:2]]},
                                                 wdata_reg, wstrb_reg));
   end

   function automatic logic fn_mapped(input logic [11:0] a);
      return a == `TSIC_OFF_MODE || a == `TSIC_OFF_ROUTE || a == `TSIC_OFF_GLOBAL ||
             a == `TSIC_OFF_STATUS || (a[1:0] == 2'h0 &&
             (a[11:8] == `TSIC_PAGE_RX_TAB || a[11:8] == `TSIC_PAGE_TX_TAB));
   endfunction

   function automatic tsic_word_t fn_read(input logic [11:0] a);
      if (a == `TSIC_OFF_MODE)
         return mode_reg;
      else if (a == `TSIC_OFF_ROUTE)
         return route_reg;
      else if (a == `TSIC_OFF_GLOBAL)
         return {28'h0000000, global_reg};
      else if (a == `TSIC_OFF_STATUS)
         return {29'h0, link_en_s, link_seen_s, pend_s[0]};
      else if (a[11:8] == `TSIC_PAGE_RX_TAB && a[1:0] == 2'h0)
         return {16'h0000, rx_tab[a[7:2]]};
      else if (a[11:8] == `TSIC_PAGE_TX_TAB && a[1:0] == 2'h0)
         return {16'h0000, tx_tab[a[7:2]]};
      else
         return 32'h0000_0000;
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= 12'h000;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TSIC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_reg    <= s_axi_awaddr;
            aw_hold_reg   <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         else if (!aw_hold_reg && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            w_hold_reg   <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         else if (!w_hold_reg && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         if (wr_go)
         begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= fn_mapped(awaddr_reg) ? `TSIC_RESP_OKAY : `TSIC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `TSIC_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= fn_read(s_axi_araddr);
         s_axi_rresp   <= fn_mapped(s_axi_araddr) ? `TSIC_RESP_OKAY : `TSIC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // ------------------------------------------------------------
   // Configuration hand-over to the link at frame boundaries
   // ------------------------------------------------------------
   logic [67:0] held_cfg_reg;
   logic        req_reg;
   logic        ack_prev_reg;
   logic [1:0]  ack_sync_reg;
   logic [1:0]  seen_sync_reg;
   logic [1:0]  en_sync_reg;
   logic        link_ack_reg;
   logic        link_seen_reg;
   logic        link_en_reg;
   logic        pending;

   assign pending     = req_reg ^ ack_sync_reg[1];
   assign pend_s      = {1'b0, pending || held_cfg_reg != {global_reg, route_reg, mode_reg}};
   assign link_seen_s = seen_sync_reg[1];
   assign link_en_s   = en_sync_reg[1];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_sync_reg  <= 2'h0;
         seen_sync_reg <= 2'h0;
         en_sync_reg   <= 2'h0;
      end
      else
      begin
         ack_sync_reg  <= {ack_sync_reg[0], link_ack_reg};
         seen_sync_reg <= {seen_sync_reg[0], link_seen_reg};
         en_sync_reg   <= {en_sync_reg[0], link_en_reg};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         held_cfg_reg <= {`TSIC_GLOBAL_RST, `TSIC_ROUTE_RST, `TSIC_MODE_RST};
         req_reg      <= 1'b0;
      end
      else if (!pending && held_cfg_reg != {global_reg, route_reg, mode_reg})
      begin
         held_cfg_reg <= {global_reg, route_reg, mode_reg};
         req_reg      <= !req_reg;
      end
   end

   // Applied copies drive controller-facing selects once the link took the update
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_prev_reg             <= 1'b0;
         tdm_mode_active          <= `TSIC_MODE_RST;
         mgmt_ctrl_tdm_connect    <= 2'h0;
         mgmt_ctrl_clock_source   <= 6'h00;
         controller_tdm_connect   <= 4'h0;
         rx_clock_select          <= 12'h000;
         tx_clock_select          <= 12'h000;
         controller_grant_support <= 4'h0;
      end
      else
      begin
         ack_prev_reg <= ack_sync_reg[1];
         if (ack_prev_reg != ack_sync_reg[1])
         begin
            tdm_mode_active <= held_cfg_reg[31:0];                     // RQ7 RQ9 RQ18
            for (int t = 0; t < 2; t++)
            begin
               mgmt_ctrl_tdm_connect[t] <=
                  held_cfg_reg[t*`TSIC_MD_HALF + `TSIC_MD_CONNECT];        // RQ3
               mgmt_ctrl_clock_source[3*t +: 3] <=
                  held_cfg_reg[t*`TSIC_MD_HALF + `TSIC_MD_CS_LSB +: 3];    // RQ3
            end
            for (int c = 0; c < 4; c++)
            begin
               controller_tdm_connect[c] <=
                  held_cfg_reg[32 + c*`TSIC_RT_STRIDE + `TSIC_RT_CONNECT]; // RQ10
               controller_grant_support[c] <=
                  held_cfg_reg[32 + c*`TSIC_RT_STRIDE + `TSIC_RT_GRANT];   // RQ12
               rx_clock_select[3*c +: 3] <=
                  held_cfg_reg[32 + c*`TSIC_RT_STRIDE + `TSIC_RT_CONNECT] ? 3'h0 :
                  held_cfg_reg[32 + c*`TSIC_RT_STRIDE + `TSIC_RT_RXCS_LSB +: 3]; // RQ11
               tx_clock_select[3*c +: 3] <=
                  held_cfg_reg[32 + c*`TSIC_RT_STRIDE + `TSIC_RT_CONNECT] ? 3'h0 :
                  held_cfg_reg[32 + c*`TSIC_RT_STRIDE + `TSIC_RT_TXCS_LSB +: 3]; // RQ11
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Link domain: first TDM framing and routing
   // ------------------------------------------------------------
   logic          lrst_meta_reg;
   logic          lrst_n;
   logic [1:0]    req_sync_reg;
   logic [18:0]   act_cfg_reg;
   logic [1:0]    rdly_reg;
   logic [1:0]    tdly_reg;
   logic [8:0]    rx_pos_reg;
   logic [8:0]    tx_pos_reg;
   tsic_link_st_t rx_st_reg;
   tsic_link_st_t tx_st_reg;
   logic          rx_start;
   logic          tx_start;
   logic          tx_sync;
   logic [5:0]    limit;
   logic [8:0]    rx_cur;
   logic [8:0]    tx_cur;
   tsic_entry_t   rx_ent;
   tsic_entry_t   tx_ent;
   tsic_diag_t    diag;
   logic          tx_bit;

   always_ff @(posedge line_rx_clock or negedge resetn)
   begin
      if (!resetn)
      begin
         lrst_meta_reg <= 1'b0;
         lrst_n        <= 1'b0;
      end
      else
      begin
         lrst_meta_reg <= 1'b1;
         lrst_n        <= lrst_meta_reg;
      end
   end

   assign diag     = tsic_diag_t'(act_cfg_reg[`TSIC_MD_DIAG_LSB +: 2]);             // RQ4
   assign tx_sync  = act_cfg_reg[`TSIC_MD_CRT] ? line_rx_sync : line_tx_sync;     // RQ6
   assign rx_start = (line_rx_sync && act_cfg_reg[`TSIC_MD_RFSD_LSB +: 2] == 2'h0)
                     || rdly_reg == 2'h1;                                            // RQ5
   assign tx_start = (tx_sync && act_cfg_reg[`TSIC_MD_TFSD_LSB +: 2] == 2'h0)
                     || tdly_reg == 2'h1;                                            // RQ5
   assign limit    = act_cfg_reg[18] ? `TSIC_LIMIT_SPLIT : `TSIC_LIMIT_FULL;      // RQ15
   assign rx_cur   = rx_start ? 9'h000 : rx_pos_reg;
   assign tx_cur   = tx_start ? 9'h000 : tx_pos_reg;
   assign rx_ent   = rx_tab[rx_cur[8:3]];
   assign tx_ent   = tx_tab[tx_cur[8:3]];
   assign tx_bit   = ctrl_tx_data[tx_ent[`TSIC_EN_CTRL_LSB +: 2]];

   always_ff @(posedge line_rx_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         req_sync_reg  <= 2'h0;
         link_ack_reg  <= 1'b0;
         act_cfg_reg   <= 19'h00000;
         link_seen_reg <= 1'b0;
         link_en_reg   <= 1'b0;
      end
      else
      begin
         req_sync_reg <= {req_sync_reg[0], req_reg};
         link_en_reg  <= act_cfg_reg[16];
         if (rx_start)
            link_seen_reg <= 1'b1;
         if (rx_start && req_sync_reg[1] != link_ack_reg)
         begin
            // Held copy stays frozen while the request is open
            act_cfg_reg  <= {held_cfg_reg[64 + `TSIC_GM_RDM_LSB +: 2],
                             held_cfg_reg[64 + `TSIC_GM_ENA], held_cfg_reg[15:0]}; // RQ18
            link_ack_reg <= req_sync_reg[1];
         end
      end
   end

   always_ff @(posedge line_rx_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         rdly_reg   <= 2'h0;
         tdly_reg   <= 2'h0;
         rx_pos_reg <= 9'h000;
         tx_pos_reg <= 9'h000;
         rx_st_reg  <= TSIC_LK_IDLE;
         tx_st_reg  <= TSIC_LK_IDLE;
      end
      else
      begin
         rdly_reg   <= fn_dly_next(line_rx_sync, act_cfg_reg[`TSIC_MD_RFSD_LSB +: 2], rdly_reg);
         tdly_reg   <= fn_dly_next(tx_sync, act_cfg_reg[`TSIC_MD_TFSD_LSB +: 2], tdly_reg);
         rx_pos_reg <= fn_adv(rx_cur[8:3], rx_cur[2:0], rx_ent[`TSIC_EN_LAST], limit); // RQ14
         tx_pos_reg <= fn_adv(tx_cur[8:3], tx_cur[2:0], tx_ent[`TSIC_EN_LAST], limit); // RQ14
         unique case (rx_st_reg)
            TSIC_LK_IDLE: if (rx_start && act_cfg_reg[16]) rx_st_reg <= TSIC_LK_RUN;
            TSIC_LK_RUN:  if (!act_cfg_reg[16]) rx_st_reg <= TSIC_LK_IDLE;          // RQ17
         endcase
         unique case (tx_st_reg)
            TSIC_LK_IDLE: if (tx_start && act_cfg_reg[16]) tx_st_reg <= TSIC_LK_RUN;
            TSIC_LK_RUN:  if (!act_cfg_reg[16]) tx_st_reg <= TSIC_LK_IDLE;          // RQ17
         endcase
      end
   end

   always_ff @(posedge line_rx_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         line_tx_data   <= 1'b1;
         slot_strobe    <= 4'h0;
         rx_route_valid <= 1'b0;
         rx_route_ctrl  <= 2'h0;
         rx_route_data  <= 1'b0;
         tx_route_ctrl  <= 2'h0;
      end
      else
      begin
         rx_route_valid <= (rx_st_reg == TSIC_LK_RUN || (rx_start && act_cfg_reg[16]))
                           && act_cfg_reg[16] && rx_ent[`TSIC_EN_VALID];              // RQ17
         slot_strobe    <= ((rx_st_reg == TSIC_LK_RUN || rx_start) && act_cfg_reg[16] &&
                            rx_ent[`TSIC_EN_VALID]) ? rx_ent[`TSIC_EN_STRB_LSB +: 4] : 4'h0;
         rx_route_ctrl  <= rx_ent[`TSIC_EN_CTRL_LSB +: 2];
         tx_route_ctrl  <= tx_ent[`TSIC_EN_CTRL_LSB +: 2];
         rx_route_data  <= (diag == TSIC_DIAG_LOOPBACK || diag == TSIC_DIAG_LOOPCTRL)
                           ? tx_bit : line_rx_data;                                     // RQ4
         if (act_cfg_reg[`TSIC_MD_STZ] && !link_seen_reg)
            line_tx_data <= 1'b0;                                                      // RQ8
         else if (diag == TSIC_DIAG_ECHO)
            line_tx_data <= line_rx_data;                                              // RQ4
         else if (diag != TSIC_DIAG_NORMAL)
            line_tx_data <= 1'b1;                                                      // RQ4
         else if (tx_st_reg == TSIC_LK_RUN && act_cfg_reg[16] && tx_ent[`TSIC_EN_VALID])
            line_tx_data <= tx_bit;
         else
            line_tx_data <= 1'b1;
      end
   end

endmodule
`default_nettype wire

//--- tsic_config_props.sv
// Port checker of the TDM serial interface configuration block
`timescale 1ns/1ps
`default_nettype none
module tsic_config_props
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire tsic_pkg::tsic_word_t s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [3:0]  controller_tdm_connect,
   input wire logic [11:0] rx_clock_select,
   input wire logic [11:0] tx_clock_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
   property p_wr_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_b_blocks; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_b_blocks: assert property (p_b_blocks) else $error("write taken early");
   property p_bresp_code; s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10}; endproperty
   a_bresp_code: assert property (p_bresp_code) else $error("bad write code");
   property p_rd_answer; s_rd_taken |-> ##[1:2] s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_r_blocks; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_blocks: assert property (p_r_blocks) else $error("read taken early");
   property p_sel_ignored; controller_tdm_connect[0] |-> rx_clock_select[2:0] == 3'h0
      && tx_clock_select[2:0] == 3'h0; endproperty
   a_sel_ignored: assert property (p_sel_ignored) else $error("clock select not ignored");
endmodule
bind tsic_config tsic_config_props chk (.*);
`default_nettype wire

//--- tsic_framer.sv
// Line-side framer model: gated receive clock, frame syncs and data
`timescale 1ns/1ps
`default_nettype none
module tsic_framer
(
   input  wire logic run,
   output var  logic line_rx_clock,
   output var  logic line_rx_sync,
   output var  logic line_tx_sync,
   output var  logic line_rx_data
);
   logic       osc = 1'b0;
   logic       gate = 1'b0;
   logic [3:0] bit_reg = 4'h0;
   always #3 osc = ~osc;
   // Clock stands still while run is low
   always @(negedge osc) gate <= run;
   assign line_rx_clock = osc & gate;
   always @(posedge osc) bit_reg <= gate ? bit_reg + 4'h1 : 4'h0;
   always @(negedge osc)
   begin
      line_rx_sync <= gate && bit_reg == 4'h0;
      line_tx_sync <= gate && bit_reg == 4'h0;
      line_rx_data <= gate ? bit_reg[0] ^ bit_reg[2] : ~line_rx_data;
   end
endmodule
`default_nettype wire

//--- tdm_serial_interface_config_tb.sv
// Register and routing testbench of the TDM serial interface configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
   $display("mismatch at %0t got %0h expected %0h", $time, a, e); end end
module tdm_serial_interface_config_tb;
   import tsic_pkg::*;
   logic clk = 0, resetn = 0, run = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, line_rx_clock, line_rx_sync, line_tx_sync, line_rx_data;
   logic line_tx_data, rx_route_valid, rx_route_data;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_clock_select, tx_clock_select;
   logic [3:0] s_axi_wstrb = 4'hf, ctrl_tx_data = 4'ha, slot_strobe, controller_tdm_connect;
   logic [3:0] controller_grant_support;
   logic [1:0] s_axi_bresp, s_axi_rresp, rx_route_ctrl, tx_route_ctrl, mgmt_ctrl_tdm_connect, resp;
   logic [5:0] mgmt_ctrl_clock_source;
   tsic_word_t s_axi_wdata = 0, s_axi_rdata, tdm_mode_active, rd;
   int bad_count = 0, checks_done = 0;
   tsic_config dut (.*);
   tsic_framer far_end (.*);
   always #12.5 clk = ~clk;
   task automatic wchk(input logic [11:0] a, input tsic_word_t d, input logic [1:0] e);
      logic ta = 0, tw = 0;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!(ta && tw))
      begin
         @(negedge clk);
         ta = ta | (s_axi_awvalid & s_axi_awready);
         tw = tw | (s_axi_wvalid & s_axi_wready);
         @(posedge clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      @(posedge clk);
      `CHK(resp, e)
   endtask
   task automatic rdt(input logic [11:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 0;
      do @(negedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [11:0] a, input tsic_word_t e);
      rdt(a);
      `CHK(rd, e)
   endtask
   // Wait until the pending update has reached the link side
   task automatic settle;
      do rdt(12'h00c); while (rd[0] !== 1'b0);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      bad_count++;
      report_and_stop;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1;
      repeat (6) @(posedge clk);
      rchk(12'h000, 32'h0);
      rchk(12'h004, 32'h0);
      $display("reset values test done");
      wchk(12'h000, 32'h8f5d_c3ff, 2'b00);
      wchk(12'h004, 32'h0000_2dff, 2'b00);
      wchk(12'h040, 32'hffff_ffff, 2'b10);
      rchk(12'h000, 32'h8f5d_c3ff);
      rchk(12'h004, 32'h0000_2dff);
      wchk(12'h100, 32'h0000_ad00, 2'b00);
      wchk(12'h008, 32'h0000_0009, 2'b00);
      settle;
      `CHK(tdm_mode_active, 32'h8f5d_c3ff)
      `CHK(mgmt_ctrl_tdm_connect, 2'b11)
      `CHK(mgmt_ctrl_clock_source, 6'h04)
      `CHK(controller_tdm_connect, 4'h1)
      `CHK(rx_clock_select, 12'h028)
      `CHK(tx_clock_select, 12'h028)
      `CHK(controller_grant_support, 4'h1)
      $display("register apply test done");
      do @(negedge clk); while (rx_route_valid !== 1'b1);
      `CHK(rx_route_ctrl, 2'h2)
      `CHK(slot_strobe, 4'h5)
      wchk(12'h008, 32'h0000_0008, 2'b00);
      settle;
      repeat (4) @(negedge clk);
      `CHK(rx_route_valid, 1'b0)
      `CHK(line_tx_data, 1'b1)
      $display("routing test done");
      report_and_stop;
   end
endmodule
`default_nettype wire
